// ==== logic/icf_pkg.sv ====
// Package with constants and types for the I2C command slave front end
package icf_pkg;

  // Slave address construction
  localparam logic [3:0] ICF_UPPER_BLANK = 4'hc; // Upper address bits of an unprogrammed part
  localparam int ICF_SYNC_STAGES = 2;

  // Strap decode levels: 0 ground, 1..6 resistor steps, 7 supply
  localparam logic [2:0] ICF_STRAP_GND = 3'h0;
  localparam logic [2:0] ICF_STRAP_VCC = 3'h7;

  // Instruction codes
  localparam logic [7:0] ICF_CMD_ID_READ = 8'h02;
  localparam logic [7:0] ICF_CMD_USER_MODE = 8'h05;
  localparam logic [7:0] ICF_CMD_CFG_NVM_READ = 8'h25;
  localparam logic [7:0] ICF_CMD_CFG_FIRST = 8'h31;
  localparam logic [7:0] ICF_CMD_CFG_LAST = 8'h35;
  localparam logic [7:0] ICF_CMD_TRIM_FIRST = 8'h41;
  localparam logic [7:0] ICF_CMD_TRIM_LAST = 8'h44;
  localparam logic [7:0] ICF_CMD_MEAS_WRITE = 8'h51;
  localparam logic [7:0] ICF_CMD_MEAS_READ = 8'h52;
  localparam logic [7:0] ICF_CMD_TAG_FIRST = 8'h61;
  localparam logic [7:0] ICF_CMD_TAG_LAST = 8'h65;
  localparam logic [7:0] ICF_CMD_FLOG_ERASE = 8'h71;
  localparam logic [7:0] ICF_CMD_FLOG_RSVD = 8'h72;
  localparam logic [7:0] ICF_CMD_FLOG_LAST = 8'h76;

  // Frame layout
  localparam logic [3:0] ICF_BIT_LAST = 4'h7; // Index of eighth data bit in a frame
  localparam logic [3:0] ICF_BIT_ACK = 4'h8;  // Ninth pulse carries the acknowledge
  localparam logic [3:0] ICF_BIT_PRE = 4'hf;  // Count after start; the clock fall that follows wraps it to zero

  // Instruction groups
  typedef enum logic [2:0] {
    ICF_GRP_NONE = 3'h0,
    ICF_GRP_STATUS = 3'h1,
    ICF_GRP_CONFIG = 3'h2,
    ICF_GRP_TRIM = 3'h3,
    ICF_GRP_MEAS = 3'h4,
    ICF_GRP_TAG = 3'h5,
    ICF_GRP_FLOG = 3'h6
  } icf_group_t;

  // Decoded instruction dispatched to the function groups
  typedef struct packed {
    icf_group_t group;
    logic [2:0] op;   // Offset of the code within its group; 7 for the config NVM read
    logic [7:0] code;
  } icf_cmd_t;

  // Write data byte with its position in the transaction
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] index; // Data frame number after the instruction
  } icf_wbyte_t;

endpackage

// ==== logic/icf_cmd_decode.sv ====
// Instruction code decoder for the command front end
`timescale 1ns/1ps

module icf_cmd_decode
  import icf_pkg::*;
(
  // Code in
  input wire logic [7:0] code,
  // Decoded out
  output icf_cmd_t cmd
);

  // Range checks for each group
  wire in_status = (code >= ICF_CMD_ID_READ) && (code <= ICF_CMD_USER_MODE);
  wire in_cfg_nvm = (code == ICF_CMD_CFG_NVM_READ);
  wire in_cfg = (code >= ICF_CMD_CFG_FIRST) && (code <= ICF_CMD_CFG_LAST);
  wire in_trim = (code >= ICF_CMD_TRIM_FIRST) && (code <= ICF_CMD_TRIM_LAST);
  wire in_meas = (code == ICF_CMD_MEAS_WRITE) || (code == ICF_CMD_MEAS_READ);
  wire in_tag = (code >= ICF_CMD_TAG_FIRST) && (code <= ICF_CMD_TAG_LAST);
  wire in_flog = (code >= ICF_CMD_FLOG_ERASE) && (code <= ICF_CMD_FLOG_LAST)
    && (code != ICF_CMD_FLOG_RSVD);

  // Group select; op is the code's offset from the group base, except 7 for code 25
  assign cmd.code = code;
  assign cmd.group = in_status ? ICF_GRP_STATUS :
                     (in_cfg_nvm || in_cfg) ? ICF_GRP_CONFIG :
                     in_trim ? ICF_GRP_TRIM :
                     in_meas ? ICF_GRP_MEAS :
                     in_tag ? ICF_GRP_TAG :
                     in_flog ? ICF_GRP_FLOG : ICF_GRP_NONE;
  assign cmd.op = in_status ? 3'(code - ICF_CMD_ID_READ) :
                  in_cfg_nvm ? 3'h7 :
                  in_cfg ? 3'(code - ICF_CMD_CFG_FIRST) :
                  in_trim ? 3'(code - ICF_CMD_TRIM_FIRST) :
                  in_meas ? 3'(code - ICF_CMD_MEAS_WRITE) :
                  in_tag ? 3'(code - ICF_CMD_TAG_FIRST) :
                  in_flog ? 3'(code - ICF_CMD_FLOG_ERASE) : 3'h0;

endmodule // icf_cmd_decode

// ==== logic/icf_slave.sv ====
// I2C command slave front end: address match, framing and dispatch
`timescale 1ns/1ps

// Behaviour
// - Address is four stored bits plus strap bits
// - Strap ground 000, supply 111, resistors between
// - Blank part upper bits read 1100
// - Byte after address is the instruction
// - Nine-pulse frames, slave acks writes
// - Second frame instruction, later frames data
// - Repeated start, read address, device sends
// - Master acks reads; device sends while allowed
// - Codes 02-05 status and mode group
// - 25 and 31-35 configuration group
// - 41-44 trim setpoints one to four
// - 51 measurement write, 52 read
// - 61-65 user tag operations
// - 71,73-76 fault log; 72 reserved
module icf_slave
  import icf_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // I2C pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address setup
  input wire logic [3:0] upper_addr_cfg,
  input wire logic upper_addr_valid,
  input wire logic [2:0] strap_level,
  // Command dispatch
  output icf_cmd_t cmd,
  output logic cmd_valid,
  output logic cmd_is_read,
  output icf_wbyte_t wbyte,
  output logic wbyte_valid,
  // Read data source
  input wire logic [7:0] rdata,
  input wire logic rdata_more,
  output logic rdata_take,
  // Status
  output logic busy,
  output logic stop_seen,
  output logic [6:0] slave_addr
);

  typedef enum logic [2:0] {
    ICF_ST_IDLE = 3'b000,
    ICF_ST_ADDR = 3'b001,
    ICF_ST_CODE = 3'b011,
    ICF_ST_WDATA = 3'b010,
    ICF_ST_RDATA = 3'b110,
    ICF_ST_IGNORE = 3'b111
  } icf_state_t;

  icf_state_t state;
  icf_state_t next_state;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_d;
  logic sda_d;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx;
  logic [7:0] data_idx;
  logic acking;
  logic master_nack;
  logic [2:0] strap_lsb;
  logic [6:0] next_slave_addr;
  icf_cmd_t dec_cmd;

  // Two-flop synchronisers on the bus pins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end
    else if (clk_en)
    begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
    end
  end

  // Delayed copies for edge detection, fed only by the second stage
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else if (clk_en)
    begin
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
    end
  end

  // Bus condition detection
  wire scl_s = scl_d;
  wire sda_s = sda_d;
  wire scl_rise = ~scl_d & scl_sync[1];
  wire scl_fall = scl_d & ~scl_sync[1];
  wire start_cond = scl_s & scl_sync[1] & sda_s & ~sda_sync[1];
  wire stop_cond = scl_s & scl_sync[1] & ~sda_s & sda_sync[1];
  wire data_bit = (bit_cnt <= ICF_BIT_LAST);
  wire byte_done = scl_fall && (bit_cnt == ICF_BIT_LAST);
  wire frame_done = scl_fall && (bit_cnt == ICF_BIT_ACK);
  wire [7:0] rx_byte = shift;

  // Strap level to lower address bits; level equals unit number
  assign strap_lsb = (strap_level == ICF_STRAP_GND) ? ICF_STRAP_GND :
                     (strap_level == ICF_STRAP_VCC) ? ICF_STRAP_VCC : strap_level;
  assign next_slave_addr = {(upper_addr_valid ? upper_addr_cfg : ICF_UPPER_BLANK), strap_lsb};

  // Resolved address register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      slave_addr <= 7'h00;
    else if (clk_en)
      slave_addr <= next_slave_addr;
  end

  // Address compare on the first frame
  wire addr_hit = (rx_byte[7:1] == slave_addr);
  wire addr_rd = rx_byte[0];

  icf_cmd_decode u_decode
  (
    .code(rx_byte),
    .cmd(dec_cmd)
  );

  // Transaction state machine
  always_comb
  begin
    next_state = state;
    unique case (state)
      ICF_ST_IDLE: next_state = state;
      ICF_ST_ADDR:
        if (frame_done)
          next_state = !addr_hit ? ICF_ST_IGNORE :
                       addr_rd ? ICF_ST_RDATA : ICF_ST_CODE;
      ICF_ST_CODE:
        if (frame_done)
          next_state = ICF_ST_WDATA;
      ICF_ST_WDATA: next_state = state;
      ICF_ST_RDATA:
        if (frame_done && master_nack)
          next_state = ICF_ST_IGNORE;
      ICF_ST_IGNORE: next_state = state;
      default: next_state = ICF_ST_IDLE;
    endcase
    if (start_cond)
      next_state = ICF_ST_ADDR;
    else if (stop_cond)
      next_state = ICF_ST_IDLE;
  end

  // State and bit counter
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= ICF_ST_IDLE;
      bit_cnt <= 4'h0;
    end
    else if (clk_en)
    begin
      state <= next_state;
      if (start_cond)
        bit_cnt <= ICF_BIT_PRE; // Clock fall after start is not a data bit
      else if (frame_done)
        bit_cnt <= 4'h0;
      else if (scl_fall)
        bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // Receive shifter, sampled on rising clock during data bits
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      shift <= 8'h00;
    else if (clk_en && scl_rise && data_bit)
      shift <= {shift[6:0], sda_s};
  end

  // Master acknowledge sampled on the ninth pulse of every frame; only read frames use it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      master_nack <= 1'b0;
    else if (clk_en && scl_rise && (bit_cnt == ICF_BIT_ACK))
      master_nack <= sda_s;
  end

  // Acknowledge drive: address hit, code and write data frames only
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      acking <= 1'b0;
    else if (clk_en)
    begin
      if (start_cond || stop_cond || frame_done)
        acking <= 1'b0;
      else if (byte_done)
        acking <= (state == ICF_ST_ADDR) ? addr_hit :
                  (state == ICF_ST_CODE) || (state == ICF_ST_WDATA);
    end
  end

  // Transmit byte: loaded after address ack and after each acked read frame while rdata_more is high
  wire load_tx = (frame_done && (state == ICF_ST_ADDR) && (next_state == ICF_ST_RDATA)) ||
                 (frame_done && (state == ICF_ST_RDATA) && !master_nack && rdata_more);
  wire ack_read_frame = (state == ICF_ST_RDATA) && !rdata_more;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tx <= 8'hff;
    else if (clk_en)
    begin
      if (load_tx)
        tx <= rdata;
      else if (ack_read_frame && frame_done)
        tx <= 8'hff; // Nothing left: release line
      else if (scl_fall && (state == ICF_ST_RDATA) && data_bit)
        tx <= {tx[6:0], 1'b1};
    end
  end

  // Address frame ack keeps state ADDR until frame ends; tracked via acking
  wire addr_frame_read = (state == ICF_ST_RDATA) && (bit_cnt == 4'h0) && acking;

  // Write byte index and dispatch pulses
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      data_idx <= 8'h00;
      cmd <= '0;
      cmd_valid <= 1'b0;
      cmd_is_read <= 1'b0;
      wbyte <= '0;
      wbyte_valid <= 1'b0;
      rdata_take <= 1'b0;
      stop_seen <= 1'b0;
    end
    else if (clk_en)
    begin
      cmd_valid <= 1'b0;
      wbyte_valid <= 1'b0;
      rdata_take <= load_tx;
      stop_seen <= stop_cond && (state != ICF_ST_IDLE) && (state != ICF_ST_IGNORE);
      if (byte_done && (state == ICF_ST_CODE))
      begin
        cmd <= dec_cmd;
        cmd_valid <= 1'b1;
        cmd_is_read <= 1'b0;
        data_idx <= 8'h00;
      end
      else if (byte_done && (state == ICF_ST_WDATA))
      begin
        wbyte <= '{data: rx_byte, index: data_idx};
        wbyte_valid <= 1'b1;
        data_idx <= data_idx + 8'h01;
      end
      else if (byte_done && (state == ICF_ST_ADDR) && addr_hit && addr_rd)
        cmd_is_read <= 1'b1;
    end
  end

  // Pin drive: ack low, or read data bits; high means release
  wire drive_rd = (state == ICF_ST_RDATA) && data_bit && !addr_frame_read && !tx[7];
  assign sda_out = 1'b0;
  assign sda_oe = acking || drive_rd;
  assign busy = (state != ICF_ST_IDLE) && (state != ICF_ST_IGNORE);

endmodule // icf_slave

// ==== dv/icf_slave_props.sv ====
// Concurrent checks on the ports of the command slave front end
`timescale 1ns/1ps

module icf_slave_props
  import icf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Pin and address setup
  input wire logic sda_out,
  input wire logic [3:0] upper_addr_cfg,
  input wire logic upper_addr_valid,
  input wire logic [2:0] strap_level,
  input wire logic [6:0] slave_addr,
  // Dispatch and status
  input wire icf_cmd_t cmd,
  input wire logic cmd_valid,
  input wire logic cmd_is_read,
  input wire logic wbyte_valid,
  input wire logic rdata_take,
  input wire logic busy,
  input wire logic stop_seen
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Steps that qualify the checks below
  sequence s_upd;
    $past(rst_n) && $past(clk_en);
  endsequence
  sequence s_read_phase;
    busy && cmd_is_read;
  endsequence

  // Address resolution and pin use
  a_addr_resolve: assert property (s_upd |->
    slave_addr == {($past(upper_addr_valid) ? $past(upper_addr_cfg) : ICF_UPPER_BLANK), $past(strap_level)})
    else $error("slave address differs from its sources");
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  // Instruction groups
  a_grp_status: assert property (cmd_valid && cmd.code inside {[8'h02:8'h05]} |->
    cmd.group == ICF_GRP_STATUS)
    else $error("status group code misdecoded");
  a_grp_config: assert property (cmd_valid && cmd.code inside {8'h25, [8'h31:8'h35]} |->
    cmd.group == ICF_GRP_CONFIG)
    else $error("config group code misdecoded");
  a_grp_trim: assert property (cmd_valid && cmd.code inside {[8'h41:8'h44]} |-> cmd.group == ICF_GRP_TRIM)
    else $error("trim group code misdecoded");
  a_grp_meas: assert property (cmd_valid && cmd.code inside {8'h51, 8'h52} |-> cmd.group == ICF_GRP_MEAS)
    else $error("measure group code misdecoded");
  a_grp_tag: assert property (cmd_valid && cmd.code inside {[8'h61:8'h65]} |-> cmd.group == ICF_GRP_TAG)
    else $error("tag group code misdecoded");
  a_grp_flog: assert property (cmd_valid && cmd.code inside {8'h71, [8'h73:8'h76]} |->
    cmd.group == ICF_GRP_FLOG)
    else $error("fault log code misdecoded");
  a_grp_none: assert property (cmd_valid &&
    !(cmd.code inside {[8'h02:8'h05], 8'h25, [8'h31:8'h35], [8'h41:8'h44], 8'h51, 8'h52, [8'h61:8'h65], 8'h71,
    [8'h73:8'h76]}) |-> cmd.group == ICF_GRP_NONE)
    else $error("reserved code given a group");
  // Framing against the transaction state
  a_frame_ours: assert property (cmd_valid || wbyte_valid |-> busy)
    else $error("frame dispatched outside our transaction");
  a_take_read: assert property (rdata_take |-> s_read_phase)
    else $error("read data taken outside a read");
  a_stop_ends: assert property (stop_seen |-> ##[0:2] !busy)
    else $error("busy stands after stop");
endmodule // icf_slave_props

bind icf_slave icf_slave_props props_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .sda_out(sda_out),
  .upper_addr_cfg(upper_addr_cfg), .upper_addr_valid(upper_addr_valid), .strap_level(strap_level),
  .slave_addr(slave_addr), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_is_read(cmd_is_read),
  .wbyte_valid(wbyte_valid), .rdata_take(rdata_take), .busy(busy), .stop_seen(stop_seen));

// ==== dv/icf_i2c_master.sv ====
// Behavioural I2C master facing the command slave
`timescale 1ns/1ps

module icf_i2c_master
(
  // Clock
  input wire logic clk,
  // Bus
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  // Bus idles released, clock standing high
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Start: data falls while clock stands high
  task automatic start();
    wait_clk(3);
    sda_low <= 1'b1;
    wait_clk(4);
    scl <= 1'b0;
  endtask

  // Repeated start with no stop before it
  task automatic rstart();
    wait_clk(3);
    sda_low <= 1'b0;
    wait_clk(3);
    scl <= 1'b1;
    start();
  endtask

  // Stop: data rises while clock stands high
  task automatic stop();
    wait_clk(3);
    sda_low <= 1'b1;
    wait_clk(3);
    scl <= 1'b1;
    wait_clk(4);
    sda_low <= 1'b0;
    wait_clk(4);
  endtask

  // One 160 ns clock pulse; data changes only while clock is low
  task automatic bit_x(input logic b, output logic s);
    wait_clk(3);
    sda_low <= !b;
    wait_clk(3);
    scl <= 1'b1;
    wait_clk(1);
    @(negedge clk);
    s = sda_line;
    @(posedge clk);
    scl <= 1'b0;
  endtask

  // Nine-pulse frame, MSB first; ninth is the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ninth, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(tx[i], s);
      rx[i] = s;
    end
    bit_x(ninth, s);
    ack = !s;
  endtask
endmodule // icf_i2c_master

// ==== dv/icf_slave_tb_top.sv ====
// Self-checking bench for the I2C command slave front end
`timescale 1ns/1ps

module icf_slave_tb_top
  import icf_pkg::*;
;
  localparam logic [6:0] TGT = 7'h2b;
  logic clk, rst_n, clk_en, upper_addr_valid, rdata_more, scl, m_low, a;
  logic cmd_valid, cmd_is_read, wbyte_valid, rdata_take, busy, stop_seen, sda_out, sda_oe;
  logic [3:0] upper_addr_cfg;
  logic [2:0] strap_level;
  logic [7:0] rdata, rx;
  logic [6:0] slave_addr;
  icf_cmd_t cmd, last_cmd;
  icf_wbyte_t wbyte;
  icf_wbyte_t wq[$];
  int failures = 0, num_checks = 0, n_cmd = 0, n_stop = 0;
  wire sda_line;

  // Pulled-up data line, low when either side pulls
  assign sda_line = !(m_low || (sda_oe && !sda_out));

  icf_slave dut_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .upper_addr_cfg(upper_addr_cfg), .upper_addr_valid(upper_addr_valid),
    .strap_level(strap_level), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_is_read(cmd_is_read), .wbyte(wbyte),
    .wbyte_valid(wbyte_valid), .rdata(rdata), .rdata_more(rdata_more), .rdata_take(rdata_take), .busy(busy),
    .stop_seen(stop_seen), .slave_addr(slave_addr));
  icf_i2c_master master_u (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(m_low));

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Record dispatch pulses and step the read source
  always @(posedge clk)
  begin
    if (cmd_valid)
      last_cmd <= cmd;
    if (wbyte_valid)
      wq.push_back(wbyte);
    n_cmd <= n_cmd + int'(cmd_valid);
    n_stop <= n_stop + int'(stop_seen);
    if (rdata_take)
      rdata <= rdata + 8'h11;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (failures == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  function automatic icf_group_t exp_grp(input logic [7:0] c);
    if (c inside {[8'h02:8'h05]}) return ICF_GRP_STATUS;
    if (c inside {8'h25, [8'h31:8'h35]}) return ICF_GRP_CONFIG;
    if (c inside {[8'h41:8'h44]}) return ICF_GRP_TRIM;
    if (c inside {8'h51, 8'h52}) return ICF_GRP_MEAS;
    if (c inside {[8'h61:8'h65]}) return ICF_GRP_TAG;
    if (c inside {8'h71, [8'h73:8'h76]}) return ICF_GRP_FLOG;
    return ICF_GRP_NONE;
  endfunction

  // Write frame with its acknowledge judged
  task automatic wr_byte(input logic [7:0] b, input logic exp_ack);
    master_u.xfer(b, 1'b1, rx, a);
    chk(16'(a), 16'(exp_ack));
  endtask

  // Blank upper bits, then every strap level
  task automatic t_addr();
    @(posedge clk);
    strap_level <= 3'h2;
    repeat (3) @(negedge clk);
    chk(16'(slave_addr), 16'h0062);
    for (int s = 0; s < 8; s++)
    begin
      @(posedge clk);
      upper_addr_valid <= 1'b1;
      upper_addr_cfg <= 4'h5;
      strap_level <= 3'(s);
      repeat (3) @(negedge clk);
      chk(16'(slave_addr), 16'({4'h5, 3'(s)}));
    end
    @(posedge clk);
    strap_level <= 3'h3;
    repeat (4) @(posedge clk);
  endtask

  // Every assigned code and some reserved ones
  task automatic t_codes();
    logic [7:0] codes[29] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h25, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h41,
      8'h42, 8'h43, 8'h44, 8'h51, 8'h52, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h71, 8'h72, 8'h73, 8'h74,
      8'h75, 8'h76, 8'h01, 8'h30};
    int c0;
    foreach (codes[i])
    begin
      c0 = n_stop;
      master_u.start();
      wr_byte({TGT, 1'b0}, 1'b1);
      wr_byte(codes[i], 1'b1);
      master_u.stop();
      repeat (6) @(posedge clk);
      chk(16'(last_cmd.code), 16'(codes[i]));
      chk(16'(last_cmd.group), 16'(exp_grp(codes[i])));
      chk(16'(n_stop), 16'(c0 + 1));
    end
  endtask

  // Two data frames after the instruction
  task automatic t_data();
    wq.delete();
    master_u.start();
    wr_byte({TGT, 1'b0}, 1'b1);
    wr_byte(8'h51, 1'b1);
    wr_byte(8'h3c, 1'b1);
    wr_byte(8'hc3, 1'b1);
    master_u.stop();
    repeat (6) @(posedge clk);
    chk(16'(wq.size()), 16'h0002);
    chk(wq[0], 16'h3c00);
    chk(wq[1], 16'hc301);
  endtask

  // Instruction write, repeated start, two bytes read
  task automatic t_read();
    master_u.start();
    wr_byte({TGT, 1'b0}, 1'b1);
    wr_byte(8'h02, 1'b1);
    master_u.rstart();
    wr_byte({TGT, 1'b1}, 1'b1);
    master_u.xfer(8'hff, 1'b0, rx, a);
    chk(16'(rx), 16'h00a5);
    chk(16'({busy, cmd_is_read}), 16'h0003);
    master_u.xfer(8'hff, 1'b1, rx, a);
    chk(16'(rx), 16'h00b6);
    master_u.stop();
    repeat (6) @(posedge clk);
  endtask

  // Foreign address is neither acknowledged nor dispatched
  task automatic t_foreign();
    int c0;
    c0 = n_cmd;
    master_u.start();
    wr_byte({TGT ^ 7'h04, 1'b0}, 1'b0);
    wr_byte(8'h02, 1'b0);
    chk(16'(busy), 16'h0000);
    master_u.stop();
    repeat (6) @(posedge clk);
    chk(16'(n_cmd), 16'(c0));
  endtask

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    upper_addr_cfg = 4'h0;
    upper_addr_valid = 1'b0;
    strap_level = 3'h0;
    rdata = 8'ha5;
    rdata_more = 1'b1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_addr();
    t_codes();
    t_data();
    t_read();
    t_foreign();
    test_done();
  end

  // Watchdog
  initial
  begin
    #1_000_000;
    failures++;
    test_done();
  end
endmodule // icf_slave_tb_top
